// [rtl/pam_port_alt_mux.sv]
// Alternate-function pin multiplexer for ports A, B and J
`timescale 1ns/1ps
module pam_port_alt_mux
   import pam_pkg::*;
(
   input  logic                 CLK,
   input  logic                 RST,
   input  logic [PORT_W-1:0]    ALT_SELECT_LOW_A,
   input  logic [PORT_W-1:0]    ALT_ENABLE_A,
   input  logic [ANA_W-1:0]     ALT_SELECT_LOW_B,
   input  logic [ANA_W-1:0]     ALT_ENABLE_B,
   input  logic [PORTJ_W-1:0]   ALT_ENABLE_J,
   input  logic [PORT_W-1:0]    GPIO_A_OUT,
   input  logic [PORT_W-1:0]    GPIO_A_OE,
   output logic [PORT_W-1:0]    GPIO_A_IN,
   input  logic [PORT_W-1:0]    GPIO_B_OUT,
   input  logic [PORT_W-1:0]    GPIO_B_OE,
   output logic [PORT_W-1:0]    GPIO_B_IN,
   input  logic [PORTJ_W-1:0]   GPIO_J_OUT,
   input  logic [PORTJ_W-1:0]   GPIO_J_OE,
   output logic [PORTJ_W-1:0]   GPIO_J_IN,
   input  logic [PORT_W-1:0]    PA_IN,
   output logic [PORT_W-1:0]    PA_OUT,
   output logic [PORT_W-1:0]    PA_OE,
   input  logic [PORT_W-1:0]    PB_IN,
   output logic [PORT_W-1:0]    PB_OUT,
   output logic [PORT_W-1:0]    PB_OE,
   input  logic [PORTJ_W-1:0]   PJ_IN,
   output logic [PORTJ_W-1:0]   PJ_OUT,
   output logic [PORTJ_W-1:0]   PJ_OE,
   output logic                 TIMER0_INPUT,
   input  logic                 TIMER0_COMPLEMENT,
   input  logic                 TIMER0_COMPLEMENT_OE,
   input  logic                 TIMER0_OUTPUT,
   output logic                 EXTERNAL_CLOCK_INPUT,
   input  logic                 UART0_DRIVER_ENABLE,
   output logic                 SECOND_EXTERNAL_CLOCK_INPUT,
   output logic                 UART0_CLEAR_TO_SEND,
   output logic                 UART0_RECEIVE_DATA,
   input  logic                 UART0_TRANSMIT_DATA,
   input  logic                 SPI0_MASTER_OUT,
   input  logic                 SPI0_MASTER_OUT_OE,
   output logic                 SPI0_MASTER_OUT_IN,
   input  logic                 SPI0_SERIAL_CLOCK,
   input  logic                 SPI0_SERIAL_CLOCK_OE,
   output logic                 SPI0_SERIAL_CLOCK_IN,
   output logic                 TIMER1_INPUT,
   input  logic                 TIMER1_COMPLEMENT,
   input  logic                 TIMER1_COMPLEMENT_OE,
   input  logic                 TIMER1_OUTPUT,
   input  logic                 I2C_SCL_PULL_LOW,
   output logic                 I2C_SCL_IN,
   input  logic                 I2C_SDA_PULL_LOW,
   output logic                 I2C_SDA_IN,
   output logic                 ANALOG_CHANNEL_ZERO,
   output logic                 ANALOG_CHANNEL_ONE,
   output logic                 ANALOG_CHANNEL_TWO,
   input  logic [PORTJ_W-1:0]   LCD_SEGMENT_J
);

   ////////////////////////////////////////////////////////////////////
   // Pad groups, their filters and output registers
   pam_pad_if #(.W(PORT_W))  pad_a (.clk(CLK), .rst(RST));
   pam_pad_if #(.W(PORT_W))  pad_b (.clk(CLK), .rst(RST));
   pam_pad_if #(.W(PORTJ_W)) pad_j (.clk(CLK), .rst(RST));

   pam_pin_sync  #(.W(PORT_W))  u_sync_a  (.pad(pad_a.sync));
   pam_pin_sync  #(.W(PORT_W))  u_sync_b  (.pad(pad_b.sync));
   pam_pin_sync  #(.W(PORTJ_W)) u_sync_j  (.pad(pad_j.sync));
   pam_pin_drive #(.W(PORT_W))  u_drive_a (.pad(pad_a.drive));
   pam_pin_drive #(.W(PORT_W))  u_drive_b (.pad(pad_b.drive));
   pam_pin_drive #(.W(PORTJ_W)) u_drive_j (.pad(pad_j.drive));

   // Raw pins in, registered drive and filtered levels out
   assign pad_a.pin_in = PA_IN;
   assign pad_b.pin_in = PB_IN;
   assign pad_j.pin_in = PJ_IN;
   assign PA_OUT       = pad_a.pin_out;
   assign PA_OE        = pad_a.pin_oe;
   assign PB_OUT       = pad_b.pin_out;
   assign PB_OE        = pad_b.pin_oe;
   assign PJ_OUT       = pad_j.pin_out;
   assign PJ_OE        = pad_j.pin_oe;
   // GPIO readback always sees the pin, even under alternate use
   assign GPIO_A_IN    = pad_a.pin_val;
   assign GPIO_B_IN    = pad_b.pin_val;
   assign GPIO_J_IN    = pad_j.pin_val;

   ////////////////////////////////////////////////////////////////////
   // Port A decode; only the low select exists, one bit per pin
   wire [PORT_W-1:0] a_pri;
   wire [PORT_W-1:0] a_sec;
   wire [PORT_W-1:0] a_val;
   wire [PORT_W-1:0] alt_a_out;
   wire [PORT_W-1:0] alt_a_oe;

   assign a_pri = ALT_ENABLE_A & ~ALT_SELECT_LOW_A;
   assign a_sec = ALT_ENABLE_A &  ALT_SELECT_LOW_A;
   assign a_val = pad_a.pin_val;

   // PA0 drives complement on select 0, is a clock input on 1
   assign alt_a_out[A_TMR0_IO] = TIMER0_COMPLEMENT;
   assign alt_a_oe[A_TMR0_IO]  = ALT_SELECT_LOW_A[A_TMR0_IO] ?
                                 DRIVE_OFF : TIMER0_COMPLEMENT_OE;
   // PA1 reserved choice leaves the pad released
   assign alt_a_out[A_TMR0_OUT] = TIMER0_OUTPUT;
   assign alt_a_oe[A_TMR0_OUT]  = ~ALT_SELECT_LOW_A[A_TMR0_OUT];
   // PA2 driver enable out, or second clock in
   assign alt_a_out[A_DRV_EN] = UART0_DRIVER_ENABLE;
   assign alt_a_oe[A_DRV_EN]  = ~ALT_SELECT_LOW_A[A_DRV_EN];
   // PA3 is input only in both settings
   assign alt_a_out[A_CTS] = PIN_RST;
   assign alt_a_oe[A_CTS]  = DRIVE_OFF;
   // PA4 receive data is input; MOSI direction is the SPI's
   assign alt_a_out[A_RXD] = SPI0_MASTER_OUT;
   assign alt_a_oe[A_RXD]  = ALT_SELECT_LOW_A[A_RXD] ?
                             SPI0_MASTER_OUT_OE : DRIVE_OFF;
   // PA5 transmit data, or SPI clock in either direction
   assign alt_a_out[A_TXD] = ALT_SELECT_LOW_A[A_TXD] ?
                             SPI0_SERIAL_CLOCK : UART0_TRANSMIT_DATA;
   assign alt_a_oe[A_TXD]  = ALT_SELECT_LOW_A[A_TXD] ?
                             SPI0_SERIAL_CLOCK_OE : DRIVE_ON;
   // PA6/PA7 I2C lines are open drain: only ever pull low
   assign alt_a_out[A_TMR1_IO] = ALT_SELECT_LOW_A[A_TMR1_IO] ?
                                 IDLE_LOW : TIMER1_COMPLEMENT;
   assign alt_a_oe[A_TMR1_IO]  = ALT_SELECT_LOW_A[A_TMR1_IO] ?
                                 I2C_SCL_PULL_LOW :
                                 TIMER1_COMPLEMENT_OE;
   assign alt_a_out[A_TMR1_OUT] = ALT_SELECT_LOW_A[A_TMR1_OUT] ?
                                  IDLE_LOW : TIMER1_OUTPUT;
   assign alt_a_oe[A_TMR1_OUT]  = ALT_SELECT_LOW_A[A_TMR1_OUT] ?
                                  I2C_SDA_PULL_LOW : DRIVE_ON;

   // Enable decides alternate versus GPIO drive per pin
   assign pad_a.next_out = (ALT_ENABLE_A & alt_a_out) |
                           (~ALT_ENABLE_A & GPIO_A_OUT);
   assign pad_a.next_oe  = (ALT_ENABLE_A & alt_a_oe) |
                           (~ALT_ENABLE_A & GPIO_A_OE);

   ////////////////////////////////////////////////////////////////////
   // Port A peripheral inputs; idle levels keep unselected ones quiet
   wire next_timer0_input;
   wire next_ext_clock;
   wire next_ext_clock2;
   wire next_cts;
   wire next_rxd;
   wire next_mosi_in;
   wire next_sck_in;
   wire next_timer1_input;
   wire next_scl_in;
   wire next_sda_in;

   assign next_timer0_input = a_pri[A_TMR0_IO] ?
                              a_val[A_TMR0_IO] : IDLE_LOW;
   assign next_ext_clock    = a_sec[A_TMR0_IO] ?
                              a_val[A_TMR0_IO] : IDLE_LOW;
   assign next_ext_clock2   = a_sec[A_DRV_EN] ?
                              a_val[A_DRV_EN] : IDLE_LOW;
   assign next_cts          = a_pri[A_CTS] ?
                              a_val[A_CTS] : IDLE_HIGH;
   assign next_rxd          = a_pri[A_RXD] ?
                              a_val[A_RXD] : IDLE_HIGH;
   assign next_mosi_in      = a_sec[A_RXD] ?
                              a_val[A_RXD] : IDLE_LOW;
   assign next_sck_in       = a_sec[A_TXD] ?
                              a_val[A_TXD] : IDLE_LOW;
   assign next_timer1_input = a_pri[A_TMR1_IO] ?
                              a_val[A_TMR1_IO] : IDLE_LOW;
   assign next_scl_in       = a_sec[A_TMR1_IO] ?
                              a_val[A_TMR1_IO] : IDLE_HIGH;
   assign next_sda_in       = a_sec[A_TMR1_OUT] ?
                              a_val[A_TMR1_OUT] : IDLE_HIGH;

   // Register peripheral inputs so they change on one edge only
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         TIMER0_INPUT                <= IDLE_LOW;
         EXTERNAL_CLOCK_INPUT        <= IDLE_LOW;
         SECOND_EXTERNAL_CLOCK_INPUT <= IDLE_LOW;
         UART0_CLEAR_TO_SEND         <= IDLE_HIGH;
         UART0_RECEIVE_DATA          <= IDLE_HIGH;
         SPI0_MASTER_OUT_IN          <= IDLE_LOW;
         SPI0_SERIAL_CLOCK_IN        <= IDLE_LOW;
         TIMER1_INPUT                <= IDLE_LOW;
         I2C_SCL_IN                  <= IDLE_HIGH;
         I2C_SDA_IN                  <= IDLE_HIGH;
      end else begin
         TIMER0_INPUT                <= next_timer0_input;
         EXTERNAL_CLOCK_INPUT        <= next_ext_clock;
         SECOND_EXTERNAL_CLOCK_INPUT <= next_ext_clock2;
         UART0_CLEAR_TO_SEND         <= next_cts;
         UART0_RECEIVE_DATA          <= next_rxd;
         SPI0_MASTER_OUT_IN          <= next_mosi_in;
         SPI0_SERIAL_CLOCK_IN        <= next_sck_in;
         TIMER1_INPUT                <= next_timer1_input;
         I2C_SCL_IN                  <= next_scl_in;
         I2C_SDA_IN                  <= next_sda_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Port B: analog pins release the pad; upper pins stay GPIO
   wire [ANA_W-1:0] next_analog;

   assign next_analog = ALT_ENABLE_B & ALT_SELECT_LOW_B;
   // Analog use and the reserved choice both need the driver off
   assign pad_b.next_out = {GPIO_B_OUT[PORT_W-1:ANA_W],
                            ~ALT_ENABLE_B & GPIO_B_OUT[ANA_W-1:0]};
   assign pad_b.next_oe  = {GPIO_B_OE[PORT_W-1:ANA_W],
                            ~ALT_ENABLE_B & GPIO_B_OE[ANA_W-1:0]};

   // Analog switch enables are registered to match pad timing
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         {ANALOG_CHANNEL_TWO, ANALOG_CHANNEL_ONE,
          ANALOG_CHANNEL_ZERO} <= ANALOG_RST;
      end else begin
         {ANALOG_CHANNEL_TWO, ANALOG_CHANNEL_ONE,
          ANALOG_CHANNEL_ZERO} <= next_analog;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Port J: single function, so no select at all
   assign pad_j.next_out = (ALT_ENABLE_J & LCD_SEGMENT_J) |
                           (~ALT_ENABLE_J & GPIO_J_OUT);
   assign pad_j.next_oe  = ALT_ENABLE_J | GPIO_J_OE;

   ////////////////////////////////////////////////////////////////////
   // Checks on the registered pin and peripheral behaviour
   // Held through the first edge after release: registers still show
   // reset values there, so a check begun on that edge would misfire
   logic rst_seen;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rst_seen <= 1'h1;
      end else begin
         rst_seen <= 1'h0;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST || rst_seen);

   sequence s_a3_cts_sel;
      ALT_ENABLE_A[A_CTS] && !ALT_SELECT_LOW_A[A_CTS];
   endsequence
   sequence s_enable_rise;
      !ALT_ENABLE_A[A_TXD] ##1
      (ALT_ENABLE_A[A_TXD] && ALT_SELECT_LOW_A[A_TXD]);
   endsequence

   property p_a0_ext_clock;
      (ALT_ENABLE_A[0] && ALT_SELECT_LOW_A[0]) |=>
         EXTERNAL_CLOCK_INPUT == $past(pad_a.pin_val[0]) && !PA_OE[0];
   endproperty
   a_a0_ext_clock: assert property (p_a0_ext_clock)
      else $error("PA0 clock input path wrong");

   property p_a1_timer0;
      (ALT_ENABLE_A[1] && !ALT_SELECT_LOW_A[1]) |=>
         PA_OE[1] && PA_OUT[1] == $past(TIMER0_OUTPUT);
   endproperty
   a_a1_timer0: assert property (p_a1_timer0)
      else $error("PA1 timer output not driven");

   property p_a2_drv_en;
      (ALT_ENABLE_A[2] && !ALT_SELECT_LOW_A[2]) |=>
         PA_OE[2] && PA_OUT[2] == $past(UART0_DRIVER_ENABLE);
   endproperty
   a_a2_drv_en: assert property (p_a2_drv_en)
      else $error("PA2 driver enable not driven");

   property p_a3_cts;
      s_a3_cts_sel |=> !PA_OE[3] &&
         UART0_CLEAR_TO_SEND == $past(pad_a.pin_val[3]);
   endproperty
   a_a3_cts: assert property (p_a3_cts)
      else $error("PA3 clear to send path wrong");

   property p_a4_mosi;
      (ALT_ENABLE_A[4] && ALT_SELECT_LOW_A[4]) |=>
         PA_OE[4] == $past(SPI0_MASTER_OUT_OE) && UART0_RECEIVE_DATA;
   endproperty
   a_a4_mosi: assert property (p_a4_mosi)
      else $error("PA4 MOSI drive wrong");

   property p_a5_txd;
      (ALT_ENABLE_A[5] && !ALT_SELECT_LOW_A[5]) |=>
         PA_OE[5] && PA_OUT[5] == $past(UART0_TRANSMIT_DATA);
   endproperty
   a_a5_txd: assert property (p_a5_txd)
      else $error("PA5 transmit data not driven");

   property p_a7_sda;
      (ALT_ENABLE_A[7] && ALT_SELECT_LOW_A[7]) |=>
         !PA_OUT[7] && PA_OE[7] == $past(I2C_SDA_PULL_LOW);
   endproperty
   a_a7_sda: assert property (p_a7_sda)
      else $error("PA7 SDA not open drain");

   property p_b0_analog;
      (ALT_ENABLE_B[0] && ALT_SELECT_LOW_B[0]) |=>
         ANALOG_CHANNEL_ZERO && !PB_OE[0];
   endproperty
   a_b0_analog: assert property (p_b0_analog)
      else $error("PB0 analog switch wrong");

   property p_b1_analog;
      !(ALT_ENABLE_B[1] && ALT_SELECT_LOW_B[1]) |=> !ANALOG_CHANNEL_ONE;
   endproperty
   a_b1_analog: assert property (p_b1_analog)
      else $error("PB1 analog switch closed");

   property p_b2_analog;
      (ALT_ENABLE_B[2] && ALT_SELECT_LOW_B[2]) |=>
         ANALOG_CHANNEL_TWO && !PB_OE[2];
   endproperty
   a_b2_analog: assert property (p_b2_analog)
      else $error("PB2 analog switch wrong");

   property p_j_lcd;
      ALT_ENABLE_J[0] |=> PJ_OE[0] && PJ_OUT[0] == $past(LCD_SEGMENT_J[0]);
   endproperty
   a_j_lcd: assert property (p_j_lcd)
      else $error("PJ0 segment not driven");

   property p_enable_rise;
      s_enable_rise |=> PA_OE[5] == $past(SPI0_SERIAL_CLOCK_OE) &&
         $past(PA_OUT[5]) == $past(GPIO_A_OUT[5], 2);
   endproperty
   a_enable_rise: assert property (p_enable_rise)
      else $error("PA5 switched before enable");

   property p_gpio_fallback;
      (ALT_ENABLE_A == '0) |=> PA_OUT == $past(GPIO_A_OUT) &&
         PA_OE == $past(GPIO_A_OE) && UART0_RECEIVE_DATA;
   endproperty
   a_gpio_fallback: assert property (p_gpio_fallback)
      else $error("Port A not plain GPIO");

endmodule

// [include/pam_pkg.sv]
// Constants shared by the port alternate-function multiplexer files
package pam_pkg;

   ////////////////////////////////////////////////////////////////////
   // Port widths
   localparam int PORT_W  = 8;
   localparam int PORTJ_W = 4;
   localparam int ANA_W   = 3;

   ////////////////////////////////////////////////////////////////////
   // Pin positions within port A
   localparam int A_TMR0_IO  = 0;
   localparam int A_TMR0_OUT = 1;
   localparam int A_DRV_EN   = 2;
   localparam int A_CTS      = 3;
   localparam int A_RXD      = 4;
   localparam int A_TXD      = 5;
   localparam int A_TMR1_IO  = 6;
   localparam int A_TMR1_OUT = 7;

   ////////////////////////////////////////////////////////////////////
   // Reset and idle values
   localparam logic                 PIN_RST    = 1'h0;
   localparam logic [2:0]           SYNC_RST   = 3'h0;
   localparam logic [ANA_W-1:0]     ANALOG_RST = 3'h0;
   localparam logic                 IDLE_LOW   = 1'h0;
   localparam logic                 IDLE_HIGH  = 1'h1;
   localparam logic                 DRIVE_ON   = 1'h1;
   localparam logic                 DRIVE_OFF  = 1'h0;

endpackage

// [include/pam_pad_if.sv]
// Pad group: raw pin input, filtered input and registered drive
`timescale 1ns/1ps
interface pam_pad_if #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst
);
   logic [W-1:0] pin_in;
   logic [W-1:0] pin_val;
   logic [W-1:0] next_out;
   logic [W-1:0] next_oe;
   logic [W-1:0] pin_out;
   logic [W-1:0] pin_oe;

   // Input filter side
   modport sync (
      input  clk,
      input  rst,
      input  pin_in,
      output pin_val
   );

   // Output register side
   modport drive (
      input  clk,
      input  rst,
      input  next_out,
      input  next_oe,
      output pin_out,
      output pin_oe
   );
endinterface

// [rtl/pam_pin_sync.sv]
// Three-stage input synchroniser with agreement filter, one per pin
`timescale 1ns/1ps
module pam_pin_sync
   import pam_pkg::*;
#(
   parameter int W = 8
) (
   pam_pad_if.sync pad
);

   ////////////////////////////////////////////////////////////////////
   // Per-pin chain; first stage feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic [2:0] stage;
      logic       val;

      // Shift the raw pin level in
      always_ff @(posedge pad.clk or posedge pad.rst) begin
         if (pad.rst) begin
            stage <= SYNC_RST;
         end else begin
            stage <= {stage[1:0], pad.pin_in[i]};
         end
      end

      // Accept a level only when stages two and three agree
      always_ff @(posedge pad.clk or posedge pad.rst) begin
         if (pad.rst) begin
            val <= PIN_RST;
         end else if (stage[1] == stage[2]) begin
            val <= stage[2];
         end
      end

      assign pad.pin_val[i] = val;
   end

endmodule

// [rtl/pam_pin_drive.sv]
// Output register stage for pin level and output enable
`timescale 1ns/1ps
module pam_pin_drive
   import pam_pkg::*;
#(
   parameter int W = 8
) (
   pam_pad_if.drive pad
);

   ////////////////////////////////////////////////////////////////////
   // Register drive so pads never see mux glitches
   always_ff @(posedge pad.clk or posedge pad.rst) begin
      if (pad.rst) begin
         pad.pin_out <= {W{PIN_RST}};
         pad.pin_oe  <= {W{DRIVE_OFF}};
      end else begin
         pad.pin_out <= pad.next_out;
         pad.pin_oe  <= pad.next_oe;
      end
   end

endmodule

// [tb/pam_pad_model.sv]
// Pad model: resolves each pin from the block's drive and an outside source
`timescale 1ns/1ps
module pam_pad_model #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   input  wire logic [W-1:0] ext_level,
   output wire logic [W-1:0] pin_level
);
   // Block wins where it drives; elsewhere the outside level shows,
   // which the bench changes on every operation so no stale value lingers
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// [tb/pam_port_alt_mux_tb.sv]
// Self-checking bench for the port alternate-function multiplexer
`timescale 1ns/1ps
module pam_port_alt_mux_tb
   import pam_pkg::*;
;
   typedef struct packed {
      logic [7:0] sa, ea;
      logic [2:0] sb, eb;
      logic [3:0] ej;
      logic [7:0] ao, aoe, bo, boe;
      logic [3:0] jo, joe;
      logic t0c, t0ce, t0o, de, txd, mo, moe, sk, ske, t1c, t1ce, t1o;
      logic scl, sda;
      logic [3:0] lcd;
      logic [7:0] xa, xb;
      logic [3:0] xj;
   } pam_stim_t;
   typedef struct packed {
      logic rs;
      logic [39:0] d, m;
      logic [32:0] i;
   } pam_note_t;

   logic      clk = 1'h0;
   logic      rst = 1'h1;
   pam_stim_t s = '0;
   pam_note_t q[$];
   int        n_mismatch = 0;
   int        checks = 0;
   wire logic [39:0] dv;
   wire logic [32:0] iv;
   wire logic [7:0]  pa_in, pb_in;
   wire logic [3:0]  pj_in;

   ////////////////////////////////////////
   // Clock at 40 MHz
   initial begin
      forever #12.5 clk = ~clk;
   end

   pam_port_alt_mux u_dut (.CLK(clk), .RST(rst),
      .ALT_SELECT_LOW_A(s.sa), .ALT_ENABLE_A(s.ea),
      .ALT_SELECT_LOW_B(s.sb), .ALT_ENABLE_B(s.eb), .ALT_ENABLE_J(s.ej),
      .GPIO_A_OUT(s.ao), .GPIO_A_OE(s.aoe), .GPIO_A_IN(iv[19:12]),
      .GPIO_B_OUT(s.bo), .GPIO_B_OE(s.boe), .GPIO_B_IN(iv[11:4]),
      .GPIO_J_OUT(s.jo), .GPIO_J_OE(s.joe), .GPIO_J_IN(iv[3:0]),
      .PA_IN(pa_in), .PA_OUT(dv[39:32]), .PA_OE(dv[31:24]),
      .PB_IN(pb_in), .PB_OUT(dv[23:16]), .PB_OE(dv[15:8]),
      .PJ_IN(pj_in), .PJ_OUT(dv[7:4]), .PJ_OE(dv[3:0]),
      .TIMER0_INPUT(iv[32]), .TIMER0_COMPLEMENT(s.t0c),
      .TIMER0_COMPLEMENT_OE(s.t0ce), .TIMER0_OUTPUT(s.t0o),
      .EXTERNAL_CLOCK_INPUT(iv[31]), .UART0_DRIVER_ENABLE(s.de),
      .SECOND_EXTERNAL_CLOCK_INPUT(iv[30]), .UART0_CLEAR_TO_SEND(iv[29]),
      .UART0_RECEIVE_DATA(iv[28]), .UART0_TRANSMIT_DATA(s.txd),
      .SPI0_MASTER_OUT(s.mo), .SPI0_MASTER_OUT_OE(s.moe),
      .SPI0_MASTER_OUT_IN(iv[27]), .SPI0_SERIAL_CLOCK(s.sk),
      .SPI0_SERIAL_CLOCK_OE(s.ske), .SPI0_SERIAL_CLOCK_IN(iv[26]),
      .TIMER1_INPUT(iv[25]), .TIMER1_COMPLEMENT(s.t1c),
      .TIMER1_COMPLEMENT_OE(s.t1ce), .TIMER1_OUTPUT(s.t1o),
      .I2C_SCL_PULL_LOW(s.scl), .I2C_SCL_IN(iv[24]),
      .I2C_SDA_PULL_LOW(s.sda), .I2C_SDA_IN(iv[23]),
      .ANALOG_CHANNEL_ZERO(iv[20]), .ANALOG_CHANNEL_ONE(iv[21]),
      .ANALOG_CHANNEL_TWO(iv[22]), .LCD_SEGMENT_J(s.lcd));

   pam_pad_model #(.W(8)) u_pad_a (.pin_out(dv[39:32]),
      .pin_oe(dv[31:24]), .ext_level(s.xa), .pin_level(pa_in));
   pam_pad_model #(.W(8)) u_pad_b (.pin_out(dv[23:16]),
      .pin_oe(dv[15:8]), .ext_level(s.xb), .pin_level(pb_in));
   pam_pad_model #(.W(4)) u_pad_j (.pin_out(dv[7:4]),
      .pin_oe(dv[3:0]), .ext_level(s.xj), .pin_level(pj_in));

   ////////////////////////////////////////
   // Compare tasks, one per kind of result
   task automatic cmp_drive(input logic [39:0] want, input logic [39:0] got);
      checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("mismatch drive t=%0t want=%h got=%h", $time, want, got);
      end
   endtask

   task automatic cmp_in(input logic [32:0] want, input logic [32:0] got);
      checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("mismatch input t=%0t want=%h got=%h", $time, want, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Reset pulse; outputs must sit at idle while it is held
   task automatic pulse_reset(input int n);
      pam_note_t e;
      @(posedge clk);
      rst <= 1'h1;
      e.rs = 1'h1;
      e.d = 40'h0;
      e.m = 40'hFF_FFFF_FFFF;
      e.i = {10'h063, 23'h0};
      q.push_back(e);
      repeat (n) @(posedge clk);
      rst <= 1'h0;
   endtask

   // Mode 0 random, 1 all enables clear, 2 all enables set with fixed select
   task automatic run_set(input int mode, input logic [7:0] sel, input int n);
      pam_stim_t v;
      pam_note_t e;
      logic [7:0] ad, ae, oa, da, ob, pa, pb, sa, en, eo;
      logic [3:0] oj, dj, pj;
      for (int k = 0; k < n; k++) begin
         v = 104'({$urandom(), $urandom(), $urandom(), $urandom()});
         if (mode == 1) begin
            v.ea = 8'h00;
            v.eb = 3'h0;
            v.ej = 4'h0;
         end
         if (mode == 2) begin
            v.ea = 8'hFF;
            v.eb = 3'h7;
            v.ej = 4'hF;
            v.sa = sel;
            v.sb = sel[2:0];
         end
         sa = v.sa;
         ad = {sa[7] ? 1'h0 : v.t1o, sa[6] ? 1'h0 : v.t1c,
               sa[5] ? v.sk : v.txd, v.mo, 1'h0, v.de, v.t0o, v.t0c};
         ae = {sa[7] ? v.sda : 1'h1, sa[6] ? v.scl : v.t1ce,
               sa[5] ? v.ske : 1'h1, sa[4] & v.moe, 1'h0, ~sa[2], ~sa[1],
               ~sa[0] & v.t0ce};
         oa = (v.ea & ae) | (~v.ea & v.aoe);
         da = (v.ea & ad) | (~v.ea & v.ao);
         ob = {v.boe[7:3], v.boe[2:0] & ~v.eb};
         oj = v.ej | v.joe;
         dj = (v.ej & v.lcd) | (~v.ej & v.jo);
         pa = (oa & da) | (~oa & v.xa);
         pb = (ob & v.bo) | (~ob & v.xb);
         pj = (oj & dj) | (~oj & v.xj);
         en = v.ea & ~sa;
         eo = v.ea & sa;
         e.rs = 1'h0;
         e.m = {oa, 8'hFF, ob, 8'hFF, oj, 4'hF};
         e.d = {da, oa, v.bo, ob, dj, oj} & e.m;
         e.i = {en[0] & pa[0], eo[0] & pa[0], eo[2] & pa[2], ~en[3] | pa[3],
                ~en[4] | pa[4], eo[4] & pa[4], eo[5] & pa[5], en[6] & pa[6],
                ~eo[6] | pa[6], ~eo[7] | pa[7], v.eb & v.sb, pa, pb, pj};
         s <= v;
         q.push_back(e);
         repeat (8) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////
   // Monitor: drive path one cycle late, input path after the filter
   initial begin
      pam_note_t e;
      forever begin
         wait (q.size() != 0);
         e = q.pop_front();
         if (!e.rs) begin
            @(posedge clk);
         end
         @(negedge clk);
         cmp_drive(e.d, dv & e.m);
         if (!e.rs) begin
            repeat (6) @(posedge clk);
            @(negedge clk);
         end
         cmp_in(e.i, iv);
      end
   end

   // Watchdog, well beyond the roughly 740 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      void'($urandom(79));
      pulse_reset(20);
      $display("test reset done");
      run_set(0, 8'h00, 40);
      $display("test random done");
      run_set(1, 8'h00, 10);
      $display("test enables clear done");
      run_set(2, 8'h00, 4);
      run_set(2, 8'h03, 4);
      run_set(2, 8'h0C, 4);
      run_set(2, 8'h10, 4);
      run_set(2, 8'h20, 4);
      run_set(2, 8'hC0, 4);
      run_set(2, 8'hFF, 4);
      $display("test selects done");
      pulse_reset(3);
      run_set(0, 8'h00, 10);
      $display("test mid reset done");
      wait (q.size() == 0);
      repeat (10) @(posedge clk);
      complete_run();
   end
endmodule
